// File: rtl/csrg_chip_select_ready_gen.sv
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "csrg_consts.svh"

module csrg_chip_select_ready_gen
	import csrg_pkg::*;
#(
	parameter int ADR_W = 12
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [ADR_W-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_cyc_start,
	input wire logic i_cyc_end,
	input wire logic [19:0] i_cyc_addr,
	input wire logic i_cyc_mem,
	input wire logic i_async_ready_in,
	input wire logic i_sync_ready_in,
	output logic o_ready,
	output logic o_top_region_select_n,
	output logic o_bottom_region_select_n,
	output logic [3:0] o_middle_region_selects_n,
	output logic [6:0] o_peripheral_selects_n
);

	// byte-lane merge of a write into a 16-bit register
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction

	// quarter index of the middle block from the one-hot size
	function automatic logic [1:0] mid_quarter(input logic [19:0] a, input logic [6:0] f);
		logic [1:0] q;
		q = 2'h0;
		for (int k = 0; k < 7; k++)
		begin
			q = f[k] ? {a[12+k], a[11+k]} : q;
		end
		return q;
	endfunction

	// three ready bits to a wait mode
	function automatic csrg_wait_type to_wait(input logic [2:0] b);
		csrg_wait_type w;
		w.ignore = b[`CSRG_RDY_IGN];
		w.count = b[1:0];
		return w;
	endfunction

	// control registers, accessed flags and cycle state
	logic [15:0] top_r, bot_r, pbase_r, mbase_r, msize_r;
	logic bot_acc_r, pbase_acc_r, mbase_acc_r, msize_acc_r;
	logic [31:0] dat_r;
	csrg_state_type state_r, state_nxt;
	csrg_sel_type sel_r, sel_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic ack_r, ign_r, ign_nxt, rdy_r, rdy_nxt, ex_r;
	logic arf1_r, arf2_r, srf1_r, srf2_r;

	// register bus decode
	wire [9:0] wb_idx = i_wb_adr[11:2];
	wire wb_req = i_wb_cyc && i_wb_stb && !ack_r;
	wire wb_wr = wb_req && i_wb_we;
	wire hit_top = (wb_idx == `CSRG_IDX_TOP) && (i_wb_adr[1:0] == 2'h0);
	wire hit_bot = (wb_idx == `CSRG_IDX_BOTTOM) && (i_wb_adr[1:0] == 2'h0);
	wire hit_pbase = (wb_idx == `CSRG_IDX_PERIPH) && (i_wb_adr[1:0] == 2'h0);
	wire hit_mbase = (wb_idx == `CSRG_IDX_MBASE) && (i_wb_adr[1:0] == 2'h0);
	wire hit_msize = (wb_idx == `CSRG_IDX_MSIZE) && (i_wb_adr[1:0] == 2'h0);
	wire [15:0] rd_mux = hit_top ? top_r :
		hit_bot ? bot_r :
		hit_pbase ? pbase_r :
		hit_mbase ? mbase_r :
		hit_msize ? msize_r : 16'h0000;

	// top and bottom region compare on the upper 16 address bits
	wire [19:0] addr = i_cyc_addr;
	wire [15:0] top_lim = {top_r[15:6], 6'h00};
	wire [15:0] bot_lim = {bot_r[15:6], 6'h3F};
	wire top_hit = i_cyc_mem && (addr[19:4] >= top_lim) && (addr <= `CSRG_TOP_END);
	wire bot_hit = i_cyc_mem && bot_acc_r && (addr >= `CSRG_BOTTOM_START)
		&& (addr[19:4] <= bot_lim);

	// middle block: base from bits 15..9, size mask from one-hot field
	wire [19:0] mid_mask = {msize_r[14:8] - 7'h01, 13'h1FFF};
	wire [19:0] mid_base = {mbase_r[15:9], 13'h0000};
	wire mid_on = mbase_acc_r && msize_acc_r;
	wire mid_hit = i_cyc_mem && mid_on && (((addr ^ mid_base) & ~mid_mask) == 20'h00000);
	wire [1:0] mid_q = mid_quarter(addr, msize_r[14:8]);

	// peripheral windows of 128 bytes above a 1K-aligned base
	wire [19:0] per_base = {pbase_r[15:6], 10'h000};
	wire [19:0] per_off = addr - per_base;
	wire per_space = (i_cyc_mem == msize_r[`CSRG_MS_BIT]);
	wire per_on = pbase_acc_r && msize_acc_r;
	wire [2:0] per_idx = per_off[9:7];
	wire per_pin_ok = msize_r[`CSRG_EX_BIT] || (per_idx < `CSRG_PER_PINS);
	wire addr_pins = per_on && !msize_r[`CSRG_EX_BIT];
	wire per_hit = per_space && per_on && (addr >= per_base) && (per_off < `CSRG_PER_SPAN)
		&& per_pin_ok;

	// wait mode per region; first match wins
	wire csrg_wait_type wait_top = to_wait(top_r[2:0]);
	wire csrg_wait_type wait_bot = to_wait(bot_r[2:0]);
	wire csrg_wait_type wait_mid = to_wait(mbase_r[2:0]);
	wire csrg_wait_type wait_per = (per_idx < 3'h4) ? to_wait(pbase_r[2:0])
		: to_wait(msize_r[2:0]);
	wire csrg_wait_type wait_none = '{ignore: 1'b0, count: 2'h0};
	wire csrg_wait_type wait_sel = top_hit ? wait_top :
		bot_hit ? wait_bot :
		mid_hit ? wait_mid :
		per_hit ? wait_per : wait_none;

	// external ready after two-flop synchronisers
	wire ext_rdy = arf2_r || srf2_r;

	// select pattern for the cycle being started
	always_comb
	begin
		sel_nxt.top_n = !top_hit;
		sel_nxt.bottom_n = !bot_hit;
		sel_nxt.mid_n = 4'hF;
		sel_nxt.per_n = 7'h7F;
		if (mid_hit)
		begin
			sel_nxt.mid_n[mid_q] = 1'b0;
		end
		if (per_hit)
		begin
			sel_nxt.per_n[per_idx] = 1'b0;
		end
		if (addr_pins)
		begin
			sel_nxt.per_n[6:5] = addr[2:1];
		end
	end

	// bus cycle sequencing and wait counting
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		ign_nxt = ign_r;
		rdy_nxt = rdy_r;
		case (state_r)
			CSRG_IDLE:
			begin
				rdy_nxt = 1'b0;
			end
			CSRG_ACTIVE:
			begin
				if (cnt_r != 2'h0)
				begin
					cnt_nxt = cnt_r - 2'h1;
				end
				rdy_nxt = (cnt_r == 2'h0) && (ign_r || ext_rdy);
			end
			default:
			begin
				state_nxt = CSRG_IDLE;
			end
		endcase
		if (i_cyc_start)
		begin
			state_nxt = CSRG_ACTIVE;
			cnt_nxt = wait_sel.count;
			ign_nxt = wait_sel.ignore;
			rdy_nxt = 1'b0;
		end
		else if (i_cyc_end)
		begin
			state_nxt = CSRG_IDLE;
			rdy_nxt = 1'b0;
		end
	end

	// cycle state registers
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state_r <= CSRG_IDLE;
			cnt_r <= 2'h0;
			ign_r <= 1'b0;
			rdy_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			ign_r <= ign_nxt;
			rdy_r <= rdy_nxt;
		end
	end

	// selects: latched at start, released at end (A1/A2 pins keep their value unless ex_r is set)
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			sel_r <= '1;
			ex_r <= 1'b1;
		end
		else if (i_cyc_start)
		begin
			sel_r <= sel_nxt;
			ex_r <= !addr_pins;
		end
		else if (i_cyc_end)
		begin
			sel_r.top_n <= 1'b1;
			sel_r.bottom_n <= 1'b1;
			sel_r.mid_n <= 4'hF;
			sel_r.per_n[4:0] <= 5'h1F;
			if (ex_r)
			begin
				sel_r.per_n[6:5] <= 2'h3;
			end
		end
	end

	// ready pin synchronisers, two flops each; idle state ignores them
	always_ff @(posedge i_clk)
	begin
		arf1_r <= i_async_ready_in;
		arf2_r <= arf1_r;
		srf1_r <= i_sync_ready_in;
		srf2_r <= srf1_r;
	end

	// register bus answer one cycle after the request; any access marks a register
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
			bot_acc_r <= 1'b0;
			pbase_acc_r <= 1'b0;
			mbase_acc_r <= 1'b0;
			msize_acc_r <= 1'b0;
		end
		else
		begin
			ack_r <= wb_req;
			if (wb_req)
			begin
				dat_r <= {16'h0000, rd_mux};
				bot_acc_r <= bot_acc_r || hit_bot;
				pbase_acc_r <= pbase_acc_r || hit_pbase;
				mbase_acc_r <= mbase_acc_r || hit_mbase;
				msize_acc_r <= msize_acc_r || hit_msize;
			end
		end
	end

	// control registers, byte-lane writes; accessed flags are set in the bus block above
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			top_r <= `CSRG_TOP_RST;
			bot_r <= `CSRG_OTHER_RST;
			pbase_r <= `CSRG_OTHER_RST;
			mbase_r <= `CSRG_OTHER_RST;
			msize_r <= `CSRG_OTHER_RST;
		end
		else if (wb_wr)
		begin
			top_r <= hit_top ? merge(top_r, i_wb_dat, i_wb_sel) : top_r;
			bot_r <= hit_bot ? merge(bot_r, i_wb_dat, i_wb_sel) : bot_r;
			pbase_r <= hit_pbase ? merge(pbase_r, i_wb_dat, i_wb_sel) : pbase_r;
			mbase_r <= hit_mbase ? merge(mbase_r, i_wb_dat, i_wb_sel) : mbase_r;
			msize_r <= hit_msize ? merge(msize_r, i_wb_dat, i_wb_sel) : msize_r;
		end
	end

	// outputs straight from flops
	assign o_wb_ack = ack_r;
	assign o_wb_dat = dat_r;
	assign o_ready = rdy_r;
	assign o_top_region_select_n = sel_r.top_n;
	assign o_bottom_region_select_n = sel_r.bottom_n;
	assign o_middle_region_selects_n = sel_r.mid_n;
	assign o_peripheral_selects_n = sel_r.per_n;

	// cycle start into a top region set for three waits, ready ignored
	sequence s_top_three_ignore;
		i_cyc_start && top_hit && (top_r[2:0] == 3'h7);
	endsequence

	// counter exhausted inside an active cycle, no new start or end
	sequence s_count_done;
		(state_r == CSRG_ACTIVE) && (cnt_r == 2'h0) && !i_cyc_start && !i_cyc_end;
	endsequence

	property p_reset_high;
		@(posedge i_clk) i_rst |=> (sel_r == '1);
	endproperty
	a_reset_high: assert property (p_reset_high)
		else $error("selects not high after reset");

	property p_top_select;
		@(posedge i_clk) disable iff (i_rst)
		(i_cyc_start && i_cyc_mem && (addr[19:4] >= top_lim)) |=> !o_top_region_select_n;
	endproperty
	a_top_select: assert property (p_top_select)
		else $error("top select missing for address above limit");

	property p_bottom_gate;
		@(posedge i_clk) disable iff (i_rst)
		!bot_acc_r |-> o_bottom_region_select_n;
	endproperty
	a_bottom_gate: assert property (p_bottom_gate)
		else $error("bottom select active before access");

	property p_mid_gate;
		@(posedge i_clk) disable iff (i_rst)
		!mid_on |-> (o_middle_region_selects_n == 4'hF);
	endproperty
	a_mid_gate: assert property (p_mid_gate)
		else $error("middle select active before access");

	property p_per_gate;
		@(posedge i_clk) disable iff (i_rst)
		!per_on |-> (o_peripheral_selects_n == 7'h7F);
	endproperty
	a_per_gate: assert property (p_per_gate)
		else $error("peripheral select active before access");

	property p_three_waits;
		@(posedge i_clk) disable iff (i_rst)
		s_top_three_ignore ##1 (!i_cyc_start && !i_cyc_end) [*4] |-> ##1 o_ready;
	endproperty
	a_three_waits: assert property (p_three_waits)
		else $error("ready not after three wait states");

	property p_no_early_ready;
		@(posedge i_clk) disable iff (i_rst)
		s_top_three_ignore |=> !o_ready [*4];
	endproperty
	a_no_early_ready: assert property (p_no_early_ready)
		else $error("ready came before wait count expired");

	property p_parallel_ready;
		@(posedge i_clk) disable iff (i_rst)
		s_count_done |=> (o_ready == (ign_r || $past(ext_rdy)));
	endproperty
	a_parallel_ready: assert property (p_parallel_ready)
		else $error("ready not combined with external ready");

	property p_addr_hold;
		@(posedge i_clk) disable iff (i_rst)
		(!ex_r && !i_cyc_start) |=> $stable(o_peripheral_selects_n[6:5]);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("latched address bits changed inside cycle");

endmodule // csrg_chip_select_ready_gen

// File: rtl/csrg_consts.svh
// What this block does
// - top region always ends at FFFFF
// - bottom region always starts at zero
// - bottom select when address at or below limit
// - bottom select idle until its register accessed
// - bottom region wait mode from its register
// - one-hot size field sets middle block size
// - middle block split into four quarter selects
// - middle base taken from base register bits
// - middle selects idle until both registers accessed
// - middle base wait mode shared by quarters
// - seven 128-byte peripheral windows above base
// - peripheral base from register bits 15 to 6
// - option bit swaps two selects for A1/A2
// - space bit picks memory or I/O peripherals
// - peripheral selects idle until both registers accessed
// - wait mode split between two peripheral groups
// - zero to three waits, ready honoured or ignored
// - three-bit wait field per select group
// - top bit ignores ready, low bits count
// - internal waits run parallel with external ready
// - top select when address at or above limit
// - top register resets to 1K, three waits
`ifndef CSRG_CONSTS_SVH
`define CSRG_CONSTS_SVH

// register indexes; byte address is four times the index
`define CSRG_IDX_TOP 10'h0A0
`define CSRG_IDX_BOTTOM 10'h0A2
`define CSRG_IDX_PERIPH 10'h0A4
`define CSRG_IDX_MBASE 10'h0A6
`define CSRG_IDX_MSIZE 10'h0A8

// reset values
`define CSRG_TOP_RST 16'hFFFB
`define CSRG_OTHER_RST 16'h0000

// fixed region ends
`define CSRG_TOP_END 20'hFFFFF
`define CSRG_BOTTOM_START 20'h00000

// field positions
`define CSRG_RDY_IGN 2
`define CSRG_EX_BIT 7
`define CSRG_MS_BIT 6

// peripheral windows
`define CSRG_PER_SPAN 20'h00380
`define CSRG_PER_PINS 3'h5

`endif

// File: rtl/csrg_pkg.sv
package csrg_pkg;

	// bus cycle tracking
	typedef enum logic {CSRG_IDLE, CSRG_ACTIVE} csrg_state_type;

	// active-low select lines, grouped
	typedef struct packed {
		logic top_n;
		logic bottom_n;
		logic [3:0] mid_n;
		logic [6:0] per_n;
	} csrg_sel_type;

	// decoded wait mode
	typedef struct packed {
		logic ignore;
		logic [1:0] count;
	} csrg_wait_type;

endpackage

// File: tb/csrg_ext_device.sv
`timescale 1ns/1ps

module csrg_ext_device
(
	input wire logic i_clk,
	input wire logic i_selected,
	input wire logic [3:0] i_lag,
	output logic o_async_ready,
	output logic o_sync_ready
);
	logic [3:0] cnt_r;

	// cycles spent selected, saturating
	always_ff @(posedge i_clk)
	begin
		if (!i_selected)
			cnt_r <= 4'h0;
		else if (cnt_r != 4'hF)
			cnt_r <= cnt_r + 4'h1;
	end

	// slow part: ready only after its own latency, low when idle
	assign o_sync_ready = i_selected && (cnt_r >= i_lag);
	assign o_async_ready = 1'b0;
endmodule // csrg_ext_device

// File: tb/csrg_chip_select_ready_gen_bench.sv
`timescale 1ns/1ps

module csrg_chip_select_ready_gen_bench;
	import csrg_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [11:0] wb_adr = 12'h000;
	logic [31:0] wb_dat = 32'h00000000;
	logic [31:0] rd_dat;
	logic wb_ack;
	logic cyc_start = 1'b0;
	logic cyc_end = 1'b0;
	logic [19:0] cyc_addr = 20'h00000;
	logic cyc_mem = 1'b1;
	logic a_rdy;
	logic s_rdy;
	logic o_ready;
	logic [3:0] lag = 4'h0;
	csrg_sel_type sel_w;
	int miscompares = 0;
	int num_checks = 0;

	// 25 MHz
	always #20 i_clk = ~i_clk;

	csrg_chip_select_ready_gen #(.ADR_W(12)) dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
		.i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(4'hF), .i_wb_dat(wb_dat),
		.o_wb_dat(rd_dat), .o_wb_ack(wb_ack), .i_cyc_start(cyc_start),
		.i_cyc_end(cyc_end), .i_cyc_addr(cyc_addr), .i_cyc_mem(cyc_mem),
		.i_async_ready_in(a_rdy), .i_sync_ready_in(s_rdy), .o_ready(o_ready),
		.o_top_region_select_n(sel_w.top_n), .o_bottom_region_select_n(sel_w.bottom_n),
		.o_middle_region_selects_n(sel_w.mid_n), .o_peripheral_selects_n(sel_w.per_n));

	csrg_ext_device ext (.i_clk(i_clk), .i_selected(sel_w != 13'h1FFF), .i_lag(lag),
		.o_async_ready(a_rdy), .o_sync_ready(s_rdy));

	// comparisons
	task automatic chk_sel(input string n, input logic [12:0] e, input logic [12:0] g);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// classic single wishbone cycle, waits for ack
	task automatic wb(input logic w, input logic [11:0] a, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		n = 0;
		@(posedge i_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat <= {16'h0000, d};
		do
		begin
			@(posedge i_clk);
			#1;
			n++;
		end
		while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50)
			miscompares++;
		q = rd_dat[15:0];
		@(posedge i_clk);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	// one bus cycle; returns edges from start to ready
	task automatic run_cyc(input logic [19:0] a, input logic m, input logic [12:0] e,
		input logic [12:0] ea, output int w);
		@(posedge i_clk);
		cyc_start <= 1'b1;
		cyc_addr <= a;
		cyc_mem <= m;
		@(posedge i_clk);
		cyc_start <= 1'b0;
		w = 99;
		for (int k = 1; k < 30 && w == 99; k++)
		begin
			@(posedge i_clk);
			#1;
			if (k == 1)
				chk_sel("select", e, sel_w);
			if (o_ready === 1'b1)
				w = k;
		end
		@(posedge i_clk);
		cyc_end <= 1'b1;
		@(posedge i_clk);
		cyc_end <= 1'b0;
		@(posedge i_clk);
		#1;
		chk_sel("after end", ea, sel_w);
	endtask

	task automatic t_reset;
		logic [15:0] q;
		int w;
		wb(1'b0, 12'h280, 16'h0000, q);
		chk_val("top reg", 16'hFFFB, q);
		wb(1'b0, 12'h004, 16'h0000, q);
		chk_val("unmapped", 16'h0000, q);
		run_cyc(20'h00000, 1'b1, 13'h1FFF, 13'h1FFF, w);
		run_cyc(20'hFFBFF, 1'b1, 13'h1FFF, 13'h1FFF, w);
		run_cyc(20'hFFC00, 1'b1, 13'h0FFF, 13'h1FFF, w);
		chk_val("top waits", 16'h0004, w[15:0]);
		lag <= 4'h8;
		run_cyc(20'hFFFFF, 1'b1, 13'h0FFF, 13'h1FFF, w);
		chk_val("ready held off", 16'h0001, {15'h0000, w > 5 && w < 20});
		lag <= 4'h0;
		wb(1'b1, 12'h280, 16'hFFFF, q);
		run_cyc(20'hFFC00, 1'b1, 13'h0FFF, 13'h1FFF, w);
		chk_val("top ignore waits", 16'h0004, w[15:0]);
		$display("test reset done");
	endtask

	task automatic t_bottom;
		logic [15:0] q;
		int w;
		wb(1'b1, 12'h288, 16'h003C, q);
		wb(1'b0, 12'h288, 16'h0000, q);
		chk_val("bottom reg", 16'h003C, q);
		run_cyc(20'h003FF, 1'b1, 13'h17FF, 13'h1FFF, w);
		chk_val("bottom waits0", 16'h0001, w[15:0]);
		run_cyc(20'h00400, 1'b1, 13'h1FFF, 13'h1FFF, w);
		wb(1'b1, 12'h288, 16'h0FFF, q);
		run_cyc(20'h0FFFF, 1'b1, 13'h17FF, 13'h1FFF, w);
		chk_val("bottom waits3", 16'h0004, w[15:0]);
		run_cyc(20'h10000, 1'b1, 13'h1FFF, 13'h1FFF, w);
		$display("test bottom done");
	endtask

	task automatic t_mid;
		logic [15:0] q;
		int w;
		wb(1'b1, 12'h298, 16'h1005, q);
		run_cyc(20'h10000, 1'b1, 13'h1FFF, 13'h1FFF, w);
		wb(1'b1, 12'h2A0, 16'h04C6, q);
		for (int k = 0; k < 4; k++)
		begin
			run_cyc(20'h10000 + k * 20'h02000 + 20'h01FFF, 1'b1,
				13'h1FFF & ~(13'h0080 << k), 13'h1FFF, w);
			chk_val("mid waits", 16'h0002, w[15:0]);
		end
		run_cyc(20'h18000, 1'b1, 13'h1FFF, 13'h1FFF, w);
		$display("test mid done");
	endtask

	task automatic t_per;
		logic [15:0] q;
		int w;
		wb(1'b1, 12'h290, 16'h2047, q);
		for (int n = 0; n < 7; n++)
		begin
			run_cyc(20'h20400 + n * 20'h00080 + ((n % 2) ? 20'h0007F : 20'h00000), 1'b1,
				13'h1FFF & ~(13'h0001 << n), 13'h1FFF, w);
			chk_val("per waits", (n < 4) ? 16'h0004 : 16'h0003, w[15:0]);
		end
		run_cyc(20'h20780, 1'b1, 13'h1FFF, 13'h1FFF, w);
		run_cyc(20'h20400, 1'b0, 13'h1FFF, 13'h1FFF, w);
		wb(1'b1, 12'h290, 16'h0047, q);
		wb(1'b1, 12'h2A0, 16'h0486, q);
		run_cyc(20'h00700, 1'b0, 13'h1FBF, 13'h1FFF, w);
		run_cyc(20'h00400, 1'b1, 13'h17FF, 13'h1FFF, w);
		wb(1'b1, 12'h2A0, 16'h0406, q);
		run_cyc(20'h00402, 1'b0, 13'h1FBE, 13'h1FBF, w);
		$display("test peripheral done");
	endtask

	// main sequence
	initial
	begin
		@(posedge i_clk);
		#1;
		chk_sel("in reset", 13'h1FFF, sel_w);
		@(posedge i_clk);
		i_rst <= 1'b0;
		t_reset();
		t_bottom();
		t_mid();
		t_per();
		end_of_test();
	end

	// watchdog
	initial
	begin
		#2000000;
		miscompares++;
		end_of_test();
	end
endmodule // csrg_chip_select_ready_gen_bench
